/* src/ucd_params.svh */
/*
 Constants of the up counter with clear and divider: register offsets,
 control field positions, codes and reset values.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef UCD_PARAMS_SVH
`define UCD_PARAMS_SVH

`define UCD_OFF_CTRL 8'h00
`define UCD_OFF_COUNT 8'h04
`define UCD_OFF_PERIOD 8'h08
`define UCD_OFF_STATUS 8'h0c
`define UCD_OFF_MASK 8'h10

`define UCD_SRC_LSB 0
`define UCD_SRC_MSB 1
`define UCD_DIV_LSB 2
`define UCD_DIV_MSB 3
`define UCD_MODE_LSB 4
`define UCD_MODE_MSB 5
`define UCD_CLR_BIT 8
`define UCD_OVF_BIT 0

`define UCD_MODE_STOP 2'h0
`define UCD_MODE_UP 2'h1
`define UCD_MODE_CONT 2'h2

`define UCD_SRC_ALT 2'h0
`define UCD_SRC_SUBMAIN 2'h1
`define UCD_SRC_AUX 2'h2
`define UCD_SRC_EXT 2'h3

`define UCD_CTRL_RESET 6'h00
`define UCD_PERIOD_RESET 16'hffff
`define UCD_DIV_CNT_RESET 3'h0

`endif

/* src/ucd_pkg.sv */
/*
 Types shared by the counter's modules.
 Assumes ucd_params.svh is on the include path.
*/
package ucd_pkg;
   `include "ucd_params.svh"
   typedef logic [1:0] ucd_mode_t;
   typedef logic [1:0] ucd_div_t;
   // Tracks the stop, clear, restart sequence that fires a spurious flag
   typedef enum logic [1:0] {UCD_ARM_IDLE, UCD_ARM_STOPPED, UCD_ARM_CLEARED} ucd_arm_e;
endpackage

/* src/ucd_tick_if.sv */
/*
 Interface between the counter control and the input divider.
 Assumes both ends share one clock, supplied to the modules directly.
*/
`timescale 1ns/1ps
interface ucd_tick_if;
   logic src_rise;
   logic [1:0] div_code;
   logic restart;
   logic ce;
   logic tick;
   modport div (input src_rise, input div_code, input restart, input ce, output tick);
   modport ctl (output src_rise, output div_code, output restart, output ce, input tick);
endinterface

/* src/ucd_divider.sv */
/*
 Input divider: turns rising edges of the chosen source into count ticks.
 Assumes src_rise is a one-cycle pulse synchronous to pclk.
*/
`timescale 1ns/1ps
`include "ucd_params.svh"
module ucd_divider
   import ucd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   ucd_tick_if.div tk
);
   logic [2:0] div_cnt_reg;
   logic first_reg;
   logic [2:0] last;

   // Ratio 1, 2, 4 or 8
   assign last = 3'((4'h1 << tk.div_code) - 4'h1);

   // First edge after clear ticks at once
   assign tk.tick = tk.src_rise & (first_reg | (div_cnt_reg == last));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_reg <= 1'b1;
      end else if (tk.ce) begin
         if (tk.restart) begin
            first_reg <= 1'b1;
         end else if (tk.src_rise) begin
            first_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg <= `UCD_DIV_CNT_RESET;
      end else if (tk.ce) begin
         if (tk.restart || tk.tick) begin
            div_cnt_reg <= `UCD_DIV_CNT_RESET;
         end else if (tk.src_rise) begin
            div_cnt_reg <= div_cnt_reg + 3'h1;
         end
      end
   end

   a_first_tick_fast: assert property (@(posedge pclk) disable iff (!presetn)
      tk.ce && first_reg && tk.src_rise && !tk.restart |-> tk.tick)
      else $error("first edge after clear did not tick");

   a_divided_tick_ratio: assert property (@(posedge pclk) disable iff (!presetn)
      tk.ce && tk.tick && !first_reg |-> div_cnt_reg == last)
      else $error("tick did not follow the divider ratio");

   c_first_with_div: cover property (@(posedge pclk) disable iff (!presetn)
      tk.ce && tk.tick && first_reg && tk.div_code != 2'h0);
endmodule

/* src/ucd_timer.sv */
/*
 Up counter with clear and divider, reached over APB, with one interrupt.
 Assumes all clock source inputs are synchronous to pclk and sampled there;
 pready is registered, so each access phase lasts two cycles.
*/
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "ucd_params.svh"
module ucd_timer
   import ucd_pkg::*;
#(
   parameter int CNT_W = 16
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic alternate_clock_input,
   input wire logic sub_main_clock,
   input wire logic aux_clock,
   input wire logic external_timer_clock,
   output logic irq
);
   ucd_tick_if tk ();

   logic [5:0] ctrl_reg;
   logic [CNT_W-1:0] count_value_reg;
   logic [CNT_W-1:0] period_compare_value_reg;
   logic overflow_flag_reg;
   logic mask_reg;
   logic [3:0] src_prev_reg;
   ucd_arm_e arm_reg;
   ucd_arm_e arm_next;
   logic [3:0] src_now;
   logic [3:0] src_rise_all;
   logic acc;
   logic wr;
   logic hit_ctrl;
   logic hit_mapped;
   logic counter_clear_bit;
   logic mode_up;
   logic mode_run;
   logic wrap_up;
   logic wrap_cont;
   logic spurious;
   logic [31:0] rd_mux;

   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   assign hit_ctrl = paddr == `UCD_OFF_CTRL;
   assign hit_mapped = hit_ctrl || paddr == `UCD_OFF_COUNT || paddr == `UCD_OFF_PERIOD
      || paddr == `UCD_OFF_STATUS || paddr == `UCD_OFF_MASK;
   assign counter_clear_bit = wr & hit_ctrl & pwdata[`UCD_CLR_BIT];
   assign mode_up = ctrl_reg[`UCD_MODE_MSB:`UCD_MODE_LSB] == `UCD_MODE_UP;
   assign mode_run = mode_up || ctrl_reg[`UCD_MODE_MSB:`UCD_MODE_LSB] == `UCD_MODE_CONT;

   // Pin inputs are synchronous, so edges are taken without synchronisers
   assign src_now = {external_timer_clock, aux_clock, sub_main_clock, alternate_clock_input};
   assign src_rise_all = src_now & ~src_prev_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_prev_reg <= 4'h0;
      end else if (ce) begin
         src_prev_reg <= src_now;
      end
   end

   assign tk.src_rise = mode_run & src_rise_all[ctrl_reg[`UCD_SRC_MSB:`UCD_SRC_LSB]];
   assign tk.div_code = ctrl_reg[`UCD_DIV_MSB:`UCD_DIV_LSB];
   assign tk.restart = counter_clear_bit;
   assign tk.ce = ce;

   ucd_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .tk(tk)
   );

   assign wrap_up = tk.tick & mode_up & (count_value_reg == period_compare_value_reg);
   assign wrap_cont = tk.tick & ~mode_up & (&count_value_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `UCD_CTRL_RESET;
         period_compare_value_reg <= CNT_W'(`UCD_PERIOD_RESET);
         mask_reg <= 1'b0;
      end else if (ce && wr) begin
         if (hit_ctrl) begin
            ctrl_reg <= pwdata[`UCD_MODE_MSB:`UCD_SRC_LSB];
         end
         if (paddr == `UCD_OFF_PERIOD) begin
            period_compare_value_reg <= pwdata[CNT_W-1:0];
         end
         if (paddr == `UCD_OFF_MASK) begin
            mask_reg <= pwdata[`UCD_OVF_BIT];
         end
      end
   end

   // Clear wins over a tick in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value_reg <= '0;
      end else if (ce) begin
         if (counter_clear_bit || wrap_up) begin
            count_value_reg <= '0;
         end else if (tk.tick) begin
            count_value_reg <= count_value_reg + CNT_W'(1);
         end
      end
   end

   // Stop at period, clear, restart in Up
   always_comb begin
      arm_next = arm_reg;
      unique case (arm_reg)
         UCD_ARM_IDLE: begin
            if (!mode_run && count_value_reg == period_compare_value_reg) begin
               arm_next = UCD_ARM_STOPPED;
            end
         end
         UCD_ARM_STOPPED: begin
            if (counter_clear_bit) begin
               arm_next = UCD_ARM_CLEARED;
            end else if (mode_run) begin
               arm_next = UCD_ARM_IDLE;
            end
         end
         UCD_ARM_CLEARED: begin
            if (mode_run && (!mode_up || src_rise_all[`UCD_SRC_EXT])) begin
               arm_next = UCD_ARM_IDLE;
            end
         end
         default: arm_next = UCD_ARM_IDLE;
      endcase
   end

   assign spurious = arm_reg == UCD_ARM_CLEARED && mode_up && src_rise_all[`UCD_SRC_EXT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_reg <= UCD_ARM_IDLE;
      end else if (ce) begin
         arm_reg <= arm_next;
      end
   end

   // Set wins over the write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_reg <= 1'b0;
      end else if (ce) begin
         if (wrap_up || wrap_cont || spurious) begin
            overflow_flag_reg <= 1'b1;
         end else if (wr && paddr == `UCD_OFF_STATUS && pwdata[`UCD_OVF_BIT]) begin
            overflow_flag_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      unique case (paddr)
         `UCD_OFF_CTRL: rd_mux = {26'h0, ctrl_reg};
         `UCD_OFF_COUNT: rd_mux = 32'(count_value_reg);
         `UCD_OFF_PERIOD: rd_mux = 32'(period_compare_value_reg);
         `UCD_OFF_STATUS: rd_mux = {31'h0, overflow_flag_reg};
         `UCD_OFF_MASK: rd_mux = {31'h0, mask_reg};
         default: rd_mux = 32'h0;
      endcase
   end

   // Registered answer costs a wait cycle but keeps outputs glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         irq <= 1'b0;
      end else if (ce) begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit_mapped;
         prdata <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0;
         irq <= overflow_flag_reg & mask_reg;
      end
   end

   a_clear_zeros_count: assert property (@(posedge pclk) disable iff (!presetn)
      ce && counter_clear_bit |=> count_value_reg == '0)
      else $error("clear did not zero the count");

   a_up_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wrap_up && !counter_clear_bit |=> count_value_reg == '0 && overflow_flag_reg)
      else $error("up wrap did not zero count and set flag");

   a_up_flag_cause: assert property (@(posedge pclk) disable iff (!presetn)
      ce && mode_up && !overflow_flag_reg && !wrap_up && !spurious |=> !overflow_flag_reg)
      else $error("flag set in up mode without wrap");

   a_spurious_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && arm_reg == UCD_ARM_CLEARED && mode_up && src_rise_all[`UCD_SRC_EXT]
      |=> overflow_flag_reg)
      else $error("restart after stop at period gave no flag");

   a_source_select: assert property (@(posedge pclk) disable iff (!presetn)
      tk.tick |-> src_rise_all[ctrl_reg[`UCD_SRC_MSB:`UCD_SRC_LSB]])
      else $error("tick without edge on the chosen source");

   a_tick_advances: assert property (@(posedge pclk) disable iff (!presetn)
      ce && tk.tick && !wrap_up && !counter_clear_bit
      |=> count_value_reg == $past(count_value_reg) + CNT_W'(1))
      else $error("tick did not advance the count");

   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      ce && overflow_flag_reg && mask_reg |=> irq)
      else $error("unmasked flag did not raise the interrupt");

   c_up_wrap: cover property (@(posedge pclk) disable iff (!presetn) ce && wrap_up);
   c_spurious: cover property (@(posedge pclk) disable iff (!presetn) ce && spurious);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule

/* verification/ucd_tb.sv */
/*
 Self-checking bench for the up counter with clear and divider.
 Assumes ucd_pkg and ucd_params.svh compiled first; clock sources are
 synchronous to pclk and ce is driven by the bench, low only in the freeze test.
*/
`timescale 1ns/1ps
`include "ucd_params.svh"
module testbench;
   import ucd_pkg::*;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] src;
   int n_fail, n_tests;
   ucd_timer #(.CNT_W(16)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .alternate_clock_input(src[0]),
      .sub_main_clock(src[1]), .aux_clock(src[2]), .external_timer_clock(src[3]), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One transfer; a leading edge keeps psel from being assigned twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      // Only the watchdog ends a wait; the answer comes in the second access cycle
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1);
      chk(32'(i), 32'h2);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
      chk({31'h0, e}, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
      chk({31'h0, e}, {31'h0, experr});
   endtask
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] d,
      input logic [1:0] s, input logic c);
      return {23'h0, c, 2'h0, m, d, s};
   endfunction
   task automatic pulse(input int i);
      @(posedge pclk);
      src[i] <= 1'b1;
      @(posedge pclk);
      src[i] <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic t_reset;
      rd(`UCD_OFF_CTRL, 32'h0, 1'b0);
      rd(`UCD_OFF_COUNT, 32'h0, 1'b0);
      rd(`UCD_OFF_PERIOD, 32'h0000ffff, 1'b0);
      rd(`UCD_OFF_STATUS, 32'h0, 1'b0);
      rd(`UCD_OFF_MASK, 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      chk({31'h0, irq}, 32'h0);
   endtask
   // Every source against every divider code: first edge ticks, then 2^d per tick
   task automatic t_div;
      for (int s = 0; s < 4; s++) begin
         for (int d = 0; d < 4; d++) begin
            wr(`UCD_OFF_CTRL, ctl(`UCD_MODE_UP, d[1:0], s[1:0], 1'b1));
            rd(`UCD_OFF_COUNT, 32'h0, 1'b0);
            pulse(s);
            rd(`UCD_OFF_COUNT, 32'h1, 1'b0);
            repeat ((1 << d) - 1) pulse(s);
            rd(`UCD_OFF_COUNT, 32'h1, 1'b0);
            pulse(s);
            rd(`UCD_OFF_COUNT, 32'h2, 1'b0);
         end
      end
      wr(`UCD_OFF_CTRL, 32'h0);
   endtask
   // Count is left at 2 while stopped, so the period write arms the spurious flag
   task automatic t_wrap;
      wr(`UCD_OFF_PERIOD, 32'h2);
      wr(`UCD_OFF_MASK, 32'h1);
      wr(`UCD_OFF_CTRL, ctl(`UCD_MODE_UP, 2'h0, 2'h0, 1'b1));
      repeat (2) pulse(0);
      rd(`UCD_OFF_STATUS, 32'h0, 1'b0);
      chk({31'h0, irq}, 32'h0);
      pulse(0);
      rd(`UCD_OFF_COUNT, 32'h0, 1'b0);
      rd(`UCD_OFF_STATUS, 32'h1, 1'b0);
      chk({31'h0, irq}, 32'h1);
      wr(`UCD_OFF_STATUS, 32'h1);
      rd(`UCD_OFF_STATUS, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
   endtask
   // Stop at period, clear, restart: an external edge flags with no wrap
   task automatic t_spur;
      wr(`UCD_OFF_CTRL, ctl(`UCD_MODE_UP, 2'h0, 2'h0, 1'b1));
      // Armed by the wrap test: first external edge flags, later ones stay quiet
      pulse(3);
      rd(`UCD_OFF_STATUS, 32'h1, 1'b0);
      wr(`UCD_OFF_STATUS, 32'h1);
      pulse(3);
      rd(`UCD_OFF_STATUS, 32'h0, 1'b0);
      repeat (2) pulse(0);
      rd(`UCD_OFF_COUNT, 32'h2, 1'b0);
      wr(`UCD_OFF_CTRL, ctl(`UCD_MODE_STOP, 2'h0, 2'h0, 1'b0));
      wr(`UCD_OFF_CTRL, ctl(`UCD_MODE_STOP, 2'h0, 2'h0, 1'b1));
      rd(`UCD_OFF_COUNT, 32'h0, 1'b0);
      wr(`UCD_OFF_CTRL, ctl(`UCD_MODE_UP, 2'h0, 2'h0, 1'b0));
      rd(`UCD_OFF_STATUS, 32'h0, 1'b0);
      pulse(3);
      rd(`UCD_OFF_STATUS, 32'h1, 1'b0);
      rd(`UCD_OFF_COUNT, 32'h0, 1'b0);
   endtask
   // Continuous passes the period with no flag; mode 3 stops; ce low freezes the count
   task automatic t_modes;
      wr(`UCD_OFF_STATUS, 32'h1);
      wr(`UCD_OFF_CTRL, ctl(`UCD_MODE_CONT, 2'h0, 2'h0, 1'b1));
      repeat (3) pulse(0);
      rd(`UCD_OFF_COUNT, 32'h3, 1'b0);
      rd(`UCD_OFF_STATUS, 32'h0, 1'b0);
      wr(`UCD_OFF_CTRL, ctl(2'h3, 2'h0, 2'h0, 1'b0));
      rd(`UCD_OFF_CTRL, 32'h30, 1'b0);
      pulse(0);
      rd(`UCD_OFF_COUNT, 32'h3, 1'b0);
      wr(`UCD_OFF_CTRL, ctl(`UCD_MODE_UP, 2'h0, 2'h0, 1'b1));
      @(posedge pclk);
      ce <= 1'b0;
      pulse(0);
      ce <= 1'b1;
      rd(`UCD_OFF_COUNT, 32'h0, 1'b0);
      pulse(0);
      rd(`UCD_OFF_COUNT, 32'h1, 1'b0);
   endtask
   task automatic complete_run;
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      n_fail = 0;
      n_tests = 0;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      src = 4'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_div();
      t_wrap();
      t_spur();
      t_modes();
      complete_run();
   end
   // Whole run is under a thousand cycles; this allows ample margin
   initial begin
      #1000000;
      n_fail++;
      complete_run();
   end
endmodule
